//--- bench/dclt_adc_model.sv
// converter model answering trim measurement requests
`timescale 1ns/100ps
module dclt_adc_model (
   input  wire logic        clk_i,
   input  wire logic        req_i,
   input  wire logic [2:0]  ch_i,
   input  wire logic        slow_i,
   input  wire logic [71:0] lvl_i,
   output logic             done_o = 1'b0,
   output logic [11:0]      data_o = 12'h000
);
   int   cnt = 0;
   logic fire;
   assign fire = req_i && !done_o && cnt >= (slow_i ? 5 : 0);
   always @(posedge clk_i)
   begin
      cnt <= (req_i && !done_o) ? cnt + 1 : 0;
      done_o <= fire;
      // outside a result the data lines toggle, so the last value returns every second cycle
      data_o <= fire ? lvl_i[ch_i*12 +: 12] : ~data_o;
   end
endmodule

//--- bench/dclt_top_tb.sv
// self-checking bench for the closed-loop trim controller
`timescale 1ns/100ps
`define CK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
   $display("[FAIL] %0t got %h", $time, a); end end
`define TO(i) if (i >= 900) begin n_mismatch++; \
   $display("[FAIL] %0t no answer", $time); finish_test(); end
module dclt_top_tb;
   import dclt_pkg::*;
   logic        clk = 0, rst_n = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, en_n = 1;
   logic        ps0 = 0, ps1 = 0, slow = 0, awr, wr, bv, arr, rv, req, done, lock;
   logic [1:0]  bresp, rrsp, rsp;
   logic [2:0]  ch;
   logic [3:0]  ws = 0;
   logic [7:0]  adr = 0, v;
   logic [11:0] adat, off;
   logic [31:0] wd = 0, rdv, rdat;
   logic [47:0] dac;
   logic [71:0] lvl = {12'h000, 12'h000, 12'h080, 12'h080, 12'h000, 12'h080};
   int          n_mismatch = 0, compares = 0;
   time         t0;
   always #20 clk = ~clk;
   dclt_adc_model adc_u (.clk_i(clk), .req_i(req), .ch_i(ch), .slow_i(slow), .lvl_i(lvl),
      .done_o(done), .data_o(adat));
   dclt_top #(.INTERVAL0_CYCLES(40), .INTERVAL1_CYCLES(60), .INTERVAL2_CYCLES(80),
      .INTERVAL3_CYCLES(100)) dut_u (.REF_CLK_I(clk), .RESET_N_I(rst_n), .AWVALID_I(awv),
      .AWREADY_O(awr), .AWADDR_I(adr), .WVALID_I(wv), .WREADY_O(wr), .WDATA_I(wd),
      .WSTRB_I(ws), .BVALID_O(bv), .BREADY_I(br), .BRESP_O(bresp), .ARVALID_I(arv),
      .ARREADY_O(arr), .ARADDR_I(adr), .RVALID_O(rv), .RREADY_I(rr), .RDATA_O(rdat),
      .RRESP_O(rrsp), .LOOP_TRIM_ENABLE_N_I(en_n), .PROFILE_SELECT_BIT0_I(ps0),
      .PROFILE_SELECT_BIT1_I(ps1), .ADC_REQ_O(req), .ADC_CH_O(ch), .ADC_DONE_I(done),
      .ADC_DATA_I(adat), .DAC_CODE_O(dac), .OFFSET_SEL_O(off), .TRIM_LOCK_O(lock));
   task automatic finish_test;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // one register access, write when w is high
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i = 0;
      @(posedge clk);
      awv <= w;
      wv <= w;
      arv <= !w;
      adr <= a;
      wd <= d;
      ws <= {4{w}};
      br <= w;
      rr <= !w;
      do @(posedge clk); while ((w ? (awr & wr) : arr) !== 1'b1 && ++i < 900);
      awv <= 0;
      wv <= 0;
      arv <= 0;
      do @(posedge clk); while ((w ? bv : rv) !== 1'b1 && ++i < 900);
      br <= 0;
      rr <= 0;
      rdv = rdat;
      rsp = w ? bresp : rrsp;
      `TO(i)
   endtask
   // wait out one correction pass, ending on channel 3
   task automatic cyc;
      int i = 0;
      while (!(req === 1'b1 && ch === 3'd3) && ++i < 900) @(posedge clk);
      while (req === 1'b1 && ++i < 900) @(posedge clk);
      `TO(i)
      repeat (5) @(posedge clk);
   endtask
   task automatic t_loop;
      `CK(dac, {6{CODE_BPZ}})
      bus(1'b1, ADDR_CFG, 32'h0000_40A6);
      bus(1'b1, 8'h10, 32'h0000_0100);
      bus(1'b1, 8'h18, 32'h0000_0100);
      bus(1'b1, 8'h1C, 32'h0000_0080);
      bus(1'b1, 8'h2C, 32'h0000_0033);
      `CK(rsp, RESP_OKAY)
      bus(1'b1, ADDR_OFFSET, 32'h0000_0E4B);
      bus(1'b1, ADDR_OFFSET, 32'h0000_0123);
      `CK(off, 12'hE4B)
      en_n <= 0;
      cyc();
      `CK(dac, {16'h8080, 8'h80, 8'h7F, 8'h33, 8'h81})
      $display("loop test done");
   endtask
   task automatic t_pause;
      int i = 0;
      // drop the enable just as a pass measures channel 0
      while (req !== 1'b1 && ++i < 900) @(posedge clk);
      `TO(i)
      en_n <= 1;
      repeat (60) @(posedge clk);
      v = dac[7:0];
      `CK(v, 8'h82)
      repeat (200) @(posedge clk);
      `CK(dac[7:0], v)
      slow <= 1;
      en_n <= 0;
      cyc();
      `CK(dac[7:0], v + 8'h01)
      bus(1'b1, PCODE_BASE, 32'h4433_2211);
      ps0 <= 1;
      ps1 <= 1;
      slow <= 0;
      repeat (200) @(posedge clk);
      bus(1'b0, TRIM_BASE, 32'h0);
      `CK(rdv[7:0], v + 8'h01)
      `CK(dac[7:0], 8'h44)
      ps1 <= 0;
      repeat (3) @(posedge clk);
      `CK(dac[7:0], 8'h22)
      ps0 <= 0;
      cyc();
      `CK(dac[7:0], v + 8'h02)
      $display("pause test done");
   endtask
   task automatic t_sat;
      bus(1'b1, TRIM_BASE, 32'h0000_00FF);
      cyc();
      cyc();
      `CK(dac[7:0], CODE_MAX)
      // bring every loop channel onto its target so the next pass locks
      bus(1'b1, 8'h10, 32'h0000_0080);
      bus(1'b1, 8'h18, 32'h0000_0080);
      cyc();
      `CK(lock, 1'b1)
      bus(1'b1, ADDR_CTRL, 32'h0000_0004);
      repeat (2) @(posedge clk);
      `CK(dac[7:0], CODE_BPZ)
      `CK(lock, 1'b0)
      bus(1'b0, 8'hFC, 32'h0);
      `CK(rsp, RESP_SLVERR)
      $display("saturation test done");
   endtask
   task automatic t_rate;
      for (int r = 0; r < 4; r++)
      begin
         bus(1'b1, ADDR_CTRL, 32'(r));
         cyc();
         cyc();
         t0 = $time;
         cyc();
         `CK($time - t0, time'(1600 + 800 * r))
      end
      $display("rate test done");
   endtask
   initial
   begin
      repeat (3) @(posedge clk);
      rst_n <= 1;
      t_loop();
      t_pause();
      t_sat();
      t_rate();
      finish_test();
   end
endmodule

//--- rtl/dclt_pkg.sv
// shared constants and types for the closed-loop trim controller
package dclt_pkg;

   localparam int          NUM_CH        = 6;
   localparam int          CODE_W        = 8;
   localparam int          ADC_W         = 12;
   localparam int          ADDR_W        = 8;
   localparam int          DIV_W         = 19;

   // trim codes
   localparam logic [7:0]  CODE_BPZ      = 8'h80;
   localparam logic [7:0]  CODE_MIN      = 8'h00;
   localparam logic [7:0]  CODE_MAX      = 8'hFF;

   // update intervals, in ns, and their length in 40 ns clock cycles
   localparam int          CLK_PERIOD_NS = 40;
   localparam int          INTERVAL0_NS  = 432000;
   localparam int          INTERVAL1_NS  = 1060000;
   localparam int          INTERVAL2_NS  = 8740000;
   localparam int          INTERVAL3_NS  = 16900000;
   localparam int          INTERVAL0_CYC = INTERVAL0_NS / CLK_PERIOD_NS;
   localparam int          INTERVAL1_CYC = INTERVAL1_NS / CLK_PERIOD_NS;
   localparam int          INTERVAL2_CYC = INTERVAL2_NS / CLK_PERIOD_NS;
   localparam int          INTERVAL3_CYC = INTERVAL3_NS / CLK_PERIOD_NS;

   // register byte offsets
   localparam logic [7:0]  ADDR_CTRL     = 8'h00;
   localparam logic [7:0]  ADDR_CFG      = 8'h04;
   localparam logic [7:0]  ADDR_OFFSET   = 8'h08;
   localparam logic [7:0]  ADDR_STATUS   = 8'h0C;
   localparam logic [7:0]  SETP_BASE     = 8'h10;
   localparam logic [7:0]  TRIM_BASE     = 8'h28;
   localparam logic [7:0]  PCODE_BASE    = 8'h40;

   // field positions
   localparam int          CTRL_RATE_LSB = 0;
   localparam int          CTRL_RST_BIT  = 2;
   localparam int          CFG_POL_LSB   = 12;
   localparam int          STAT_BUSY_BIT = 0;
   localparam int          STAT_RUN_BIT  = 1;
   localparam int          STAT_LOCK_BIT = 2;
   localparam int          STAT_OLCK_BIT = 3;

   // reset values
   localparam logic [1:0]  RATE_RESET    = 2'b00;
   localparam logic [31:0] PCODE_RESET   = 32'h8080_8080;

   // register kinds out of the address decoder
   localparam logic [2:0]  KIND_NONE     = 3'h0;
   localparam logic [2:0]  KIND_CTRL     = 3'h1;
   localparam logic [2:0]  KIND_CFG      = 3'h2;
   localparam logic [2:0]  KIND_OFFSET   = 3'h3;
   localparam logic [2:0]  KIND_STATUS   = 3'h4;
   localparam logic [2:0]  KIND_SETP     = 3'h5;
   localparam logic [2:0]  KIND_TRIM     = 3'h6;
   localparam logic [2:0]  KIND_PCODE    = 3'h7;

   // comparator result: +1, -1, 0
   localparam logic [1:0]  CMP_EQ        = 2'b00;
   localparam logic [1:0]  CMP_UP        = 2'b01;
   localparam logic [1:0]  CMP_DN        = 2'b11;

   localparam logic [1:0]  RESP_OKAY     = 2'b00;
   localparam logic [1:0]  RESP_SLVERR   = 2'b10;

   typedef enum logic [1:0] {MODE_STORED, MODE_HOST, MODE_LOOP, MODE_SPARE} dclt_mode_type;
   typedef enum logic [1:0] {FSM_IDLE, FSM_SEL, FSM_WAIT, FSM_NEXT} dclt_fsm_type;

endpackage

//--- rtl/dclt_rate_div.sv
// update-interval divider producing a one-cycle tick
`timescale 1ns/100ps
module dclt_rate_div #(
   parameter int unsigned CYC0 = 10800,
   parameter int unsigned CYC1 = 26500,
   parameter int unsigned CYC2 = 218500,
   parameter int unsigned CYC3 = 422500
) (
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic [1:0] rate_i,
   output logic            tick_o
);
   import dclt_pkg::*;

   typedef struct packed {
      logic [DIV_W-1:0] cnt;
      logic             tick;
   } dclt_div_type;

   dclt_div_type     s_r;
   dclt_div_type     s_n;
   logic [DIV_W-1:0] last;

   always_comb
   begin
      if (rate_i == 2'b00)
         last = DIV_W'(CYC0 - 1);
      else if (rate_i == 2'b01)
         last = DIV_W'(CYC1 - 1);
      else if (rate_i == 2'b10)
         last = DIV_W'(CYC2 - 1);
      else
         last = DIV_W'(CYC3 - 1);
      s_n      = s_r;
      s_n.tick = 1'b0;
      // a shorter rate picked mid-count wraps at once
      if (s_r.cnt >= last)
      begin
         s_n.cnt  = '0;
         s_n.tick = 1'b1;
      end
      else
         s_n.cnt = s_r.cnt + DIV_W'(1);
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         s_r <= '0;
      else
         s_r <= s_n;
   end

   assign tick_o = s_r.tick;

   chk_tick_gap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      tick_o |=> !tick_o)
      else $error("interval tick lasted more than one cycle");

endmodule

//--- rtl/dclt_step.sv
// three-state compare and saturating one-step code update
`timescale 1ns/100ps
module dclt_step (
   input  wire logic [dclt_pkg::ADC_W-1:0]  setpoint_i,
   input  wire logic [dclt_pkg::ADC_W-1:0]  measured_i,
   input  wire logic                        invert_i,
   input  wire logic [dclt_pkg::CODE_W-1:0] code_i,
   output logic [1:0]                       cmp_o,
   output logic [dclt_pkg::CODE_W-1:0]      code_o
);
   import dclt_pkg::*;

   logic up;

   always_comb
   begin
      if (setpoint_i > measured_i)
         cmp_o = CMP_UP;
      else if (setpoint_i < measured_i)
         cmp_o = CMP_DN;
      else
         cmp_o = CMP_EQ;
      // polarity flips the direction of the correction
      up     = (cmp_o == CMP_UP) ^ invert_i;
      code_o = code_i;
      if (cmp_o != CMP_EQ)
      begin
         if (up && code_i != CODE_MAX)
            code_o = code_i + CODE_W'(1);
         else if (!up && code_i != CODE_MIN)
            code_o = code_i - CODE_W'(1);
      end
   end

endmodule

//--- rtl/dclt_top.sv
// closed-loop trim controller with AXI4-Lite register access
//
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps

// Functional notes
// - each update interval, run one correction cycle over every closed-loop channel
// - compare gives +1 target above, -1 target below, 0 equal
// - step trim code by one per cycle, direction from result and polarity
// - rate 00/01/10/11 selects 432 us, 1.06 ms, 8.74 ms, 16.9 ms
// - closed-loop channel measures the monitor input of its own index
// - low enable starts trimming on all closed-loop channels together
// - stored-code and host-code channels ignore the enable pin
// - on enable release, finish the running cycle, then pause
// - while paused each DAC holds its last code
// - on resume continue from the current code, no reinitialise
// - profile pins not both zero pause trimming like enable release
// - with enable held on, trimming starts at the first interval tick once a channel is in closed loop
// - at power-up every trim code is 80h
// - host may preload the trim code at the host-code address
// - DAC takes 8-bit bipolar code, 80h is bipolar zero
// - output offset is one of four, fixed once configured
// - target comes from a per-channel setpoint register
// - profile 00 is the only one where closed loop drives the DAC
// - each channel picks its profile-zero mode independently
// - reset command returns closed-loop channel codes to 80h, lock returns after a full cycle
module dclt_top #(
   parameter int unsigned INTERVAL0_CYCLES = dclt_pkg::INTERVAL0_CYC,
   parameter int unsigned INTERVAL1_CYCLES = dclt_pkg::INTERVAL1_CYC,
   parameter int unsigned INTERVAL2_CYCLES = dclt_pkg::INTERVAL2_CYC,
   parameter int unsigned INTERVAL3_CYCLES = dclt_pkg::INTERVAL3_CYC
) (
   input  wire logic                                     REF_CLK_I,
   input  wire logic                                     RESET_N_I,
   input  wire logic                                     AWVALID_I,
   output logic                                          AWREADY_O,
   input  wire logic [dclt_pkg::ADDR_W-1:0]              AWADDR_I,
   input  wire logic                                     WVALID_I,
   output logic                                          WREADY_O,
   input  wire logic [31:0]                              WDATA_I,
   input  wire logic [3:0]                               WSTRB_I,
   output logic                                          BVALID_O,
   input  wire logic                                     BREADY_I,
   output logic [1:0]                                    BRESP_O,
   input  wire logic                                     ARVALID_I,
   output logic                                          ARREADY_O,
   input  wire logic [dclt_pkg::ADDR_W-1:0]              ARADDR_I,
   output logic                                          RVALID_O,
   input  wire logic                                     RREADY_I,
   output logic [31:0]                                   RDATA_O,
   output logic [1:0]                                    RRESP_O,
   input  wire logic                                     LOOP_TRIM_ENABLE_N_I,
   input  wire logic                                     PROFILE_SELECT_BIT0_I,
   input  wire logic                                     PROFILE_SELECT_BIT1_I,
   output logic                                          ADC_REQ_O,
   output logic [2:0]                                    ADC_CH_O,
   input  wire logic                                     ADC_DONE_I,
   input  wire logic [dclt_pkg::ADC_W-1:0]               ADC_DATA_I,
   output logic [dclt_pkg::NUM_CH*dclt_pkg::CODE_W-1:0]  DAC_CODE_O,
   output logic [dclt_pkg::NUM_CH*2-1:0]                 OFFSET_SEL_O,
   output logic                                          TRIM_LOCK_O
);
   import dclt_pkg::*;

   typedef struct packed {
      dclt_fsm_type                           st;
      logic [2:0]                             ch;
      logic [1:0]                             rate;
      dclt_mode_type [NUM_CH-1:0]             mode;
      logic [NUM_CH-1:0]                      pol;
      logic [NUM_CH-1:0][1:0]                 ofs;
      logic                                   ofs_lock;
      logic [NUM_CH-1:0][ADC_W-1:0]           setp;
      logic [NUM_CH-1:0][CODE_W-1:0]          trim;
      logic [NUM_CH-1:0][31:0]                pcode;
      logic [NUM_CH-1:0][CODE_W-1:0]          dac;
      logic                                   lock;
      logic                                   miss;
      logic                                   adc_req;
      logic                                   bvalid;
      logic [1:0]                             bresp;
      logic                                   rvalid;
      logic [1:0]                             rresp;
      logic [31:0]                            rdata;
   } dclt_state_type;

   dclt_state_type       s_r;
   dclt_state_type       s_n;
   logic                 tick;
   logic                 run_ok;
   logic                 any_loop;
   logic [1:0]           prof;
   logic                 wr_fire;
   logic                 rd_fire;
   logic [5:0]           wr_dec;
   logic [5:0]           rd_dec;
   logic                 rst_cmd;
   logic                 wr_trim;
   logic [1:0]           step_cmp;
   logic [CODE_W-1:0]    step_code;
   logic [31:0]          cfg_word;
   logic [31:0]          rd_word;
   logic [CODE_W-1:0]    prof_code0;

   // returns {kind, channel} for a byte address
   function automatic logic [5:0] reg_decode(input logic [ADDR_W-1:0] a);
      logic [7:0] rel;
      rel = '0;
      reg_decode = {KIND_NONE, 3'd0};
      if (a[1:0] != 2'b00)
         reg_decode = {KIND_NONE, 3'd0};
      else if (a == ADDR_CTRL)
         reg_decode = {KIND_CTRL, 3'd0};
      else if (a == ADDR_CFG)
         reg_decode = {KIND_CFG, 3'd0};
      else if (a == ADDR_OFFSET)
         reg_decode = {KIND_OFFSET, 3'd0};
      else if (a == ADDR_STATUS)
         reg_decode = {KIND_STATUS, 3'd0};
      else if (a >= SETP_BASE && a < SETP_BASE + 8'(4 * NUM_CH))
      begin
         rel = a - SETP_BASE;
         reg_decode = {KIND_SETP, rel[4:2]};
      end
      else if (a >= TRIM_BASE && a < TRIM_BASE + 8'(4 * NUM_CH))
      begin
         rel = a - TRIM_BASE;
         reg_decode = {KIND_TRIM, rel[4:2]};
      end
      else if (a >= PCODE_BASE && a < PCODE_BASE + 8'(4 * NUM_CH))
      begin
         rel = a - PCODE_BASE;
         reg_decode = {KIND_PCODE, rel[4:2]};
      end
   endfunction

   // merges write data into a word under byte strobes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      merge = old;
      for (int b = 0; b < 4; b++)
      begin
         if (strb[b])
            merge[8*b +: 8] = nw[8*b +: 8];
      end
   endfunction

   dclt_rate_div #(
      .CYC0 (INTERVAL0_CYCLES),
      .CYC1 (INTERVAL1_CYCLES),
      .CYC2 (INTERVAL2_CYCLES),
      .CYC3 (INTERVAL3_CYCLES)
   ) u_div (
      .clk_i   (REF_CLK_I),
      .rst_n_i (RESET_N_I),
      .rate_i  (s_r.rate),
      .tick_o  (tick)
   );

   dclt_step u_step (
      .setpoint_i (s_r.setp[s_r.ch]),
      .measured_i (ADC_DATA_I),
      .invert_i   (s_r.pol[s_r.ch]),
      .code_i     (s_r.trim[s_r.ch]),
      .cmp_o      (step_cmp),
      .code_o     (step_code)
   );

   assign prof    = {PROFILE_SELECT_BIT1_I, PROFILE_SELECT_BIT0_I};
   assign run_ok  = !LOOP_TRIM_ENABLE_N_I && prof == 2'b00;
   assign wr_fire = AWVALID_I && WVALID_I && !s_r.bvalid;
   assign rd_fire = ARVALID_I && !s_r.rvalid;
   assign wr_dec  = reg_decode(AWADDR_I);
   assign rd_dec  = reg_decode(ARADDR_I);
   assign rst_cmd = wr_fire && wr_dec[5:3] == KIND_CTRL && WSTRB_I[0]
                    && WDATA_I[CTRL_RST_BIT];
   assign wr_trim = wr_fire && wr_dec[5:3] == KIND_TRIM && WSTRB_I[0];
   assign prof_code0 = s_r.pcode[0][8*prof +: 8];

   always_comb
   begin
      any_loop = 1'b0;
      cfg_word = '0;
      for (int i = 0; i < NUM_CH; i++)
      begin
         any_loop = any_loop | (s_r.mode[i] == MODE_LOOP);
         cfg_word[2*i +: 2] = s_r.mode[i];
      end
      cfg_word[CFG_POL_LSB +: NUM_CH] = s_r.pol;
   end

   // read data for the address on the read channel
   always_comb
   begin
      rd_word = '0;
      if (rd_dec[5:3] == KIND_CTRL)
         rd_word[CTRL_RATE_LSB +: 2] = s_r.rate;
      else if (rd_dec[5:3] == KIND_CFG)
         rd_word = cfg_word;
      else if (rd_dec[5:3] == KIND_OFFSET)
         rd_word[2*NUM_CH-1:0] = s_r.ofs;
      else if (rd_dec[5:3] == KIND_STATUS)
      begin
         rd_word[STAT_BUSY_BIT] = s_r.st != FSM_IDLE;
         rd_word[STAT_RUN_BIT]  = run_ok;
         rd_word[STAT_LOCK_BIT] = s_r.lock;
         rd_word[STAT_OLCK_BIT] = s_r.ofs_lock;
      end
      else if (rd_dec[5:3] == KIND_SETP)
         rd_word[ADC_W-1:0] = s_r.setp[rd_dec[2:0]];
      else if (rd_dec[5:3] == KIND_TRIM)
         rd_word[CODE_W-1:0] = s_r.trim[rd_dec[2:0]];
      else if (rd_dec[5:3] == KIND_PCODE)
         rd_word = s_r.pcode[rd_dec[2:0]];
   end

   always_comb
   begin
      s_n = s_r;
      // correction sequencer; once started, a cycle runs to its end unless a reset command aborts it
      case (s_r.st)
         FSM_IDLE:
         begin
            if (tick && run_ok && any_loop)
            begin
               s_n.ch = 3'd0;
               s_n.st = FSM_SEL;
            end
         end
         FSM_SEL:
         begin
            if (s_r.mode[s_r.ch] == MODE_LOOP)
            begin
               s_n.adc_req = 1'b1;
               s_n.st      = FSM_WAIT;
            end
            else
               s_n.st = FSM_NEXT;
         end
         FSM_WAIT:
         begin
            if (ADC_DONE_I)
            begin
               s_n.adc_req      = 1'b0;
               s_n.trim[s_r.ch] = step_code;
               if (step_cmp != CMP_EQ)
                  s_n.miss = 1'b1;
               s_n.st = FSM_NEXT;
            end
         end
         FSM_NEXT:
         begin
            if (s_r.ch == 3'(NUM_CH - 1))
            begin
               s_n.lock = !s_r.miss;
               s_n.miss = 1'b0;
               s_n.st   = FSM_IDLE;
            end
            else
            begin
               s_n.ch = s_r.ch + 3'd1;
               s_n.st = FSM_SEL;
            end
         end
         default:
            s_n.st = FSM_IDLE;
      endcase

      // register bus, write side
      if (s_r.bvalid && BREADY_I)
         s_n.bvalid = 1'b0;
      if (wr_fire)
      begin
         s_n.bvalid = 1'b1;
         s_n.bresp  = RESP_OKAY;
         if (wr_dec[5:3] == KIND_CTRL)
         begin
            if (WSTRB_I[0])
               s_n.rate = WDATA_I[CTRL_RATE_LSB +: 2];
         end
         else if (wr_dec[5:3] == KIND_CFG)
         begin
            for (int i = 0; i < NUM_CH; i++)
            begin
               s_n.mode[i] = dclt_mode_type'(merge(cfg_word, WDATA_I, WSTRB_I)
                                               >> (2 * i));
            end
            s_n.pol = NUM_CH'(merge(cfg_word, WDATA_I, WSTRB_I) >> CFG_POL_LSB);
         end
         else if (wr_dec[5:3] == KIND_OFFSET)
         begin
            // offset choice is frozen after its first write
            if (!s_r.ofs_lock)
            begin
               s_n.ofs      = (2 * NUM_CH)'(merge(32'h0000_0000, WDATA_I, WSTRB_I));
               s_n.ofs_lock = 1'b1;
            end
         end
         else if (wr_dec[5:3] == KIND_SETP)
            s_n.setp[wr_dec[2:0]] = ADC_W'(merge(32'(s_r.setp[wr_dec[2:0]]), WDATA_I,
                                                 WSTRB_I));
         else if (wr_dec[5:3] == KIND_TRIM)
         begin
            if (WSTRB_I[0])
               s_n.trim[wr_dec[2:0]] = WDATA_I[CODE_W-1:0];
         end
         else if (wr_dec[5:3] == KIND_PCODE)
            s_n.pcode[wr_dec[2:0]] = merge(s_r.pcode[wr_dec[2:0]], WDATA_I, WSTRB_I);
         else if (wr_dec[5:3] == KIND_NONE)
            s_n.bresp = RESP_SLVERR;
      end

      // reset command aborts the cycle and recentres loop channels
      if (rst_cmd)
      begin
         for (int i = 0; i < NUM_CH; i++)
         begin
            if (s_r.mode[i] == MODE_LOOP)
               s_n.trim[i] = CODE_BPZ;
         end
         s_n.lock    = 1'b0;
         s_n.miss    = 1'b0;
         s_n.adc_req = 1'b0;
         s_n.st      = FSM_IDLE;
      end

      // register bus, read side
      if (s_r.rvalid && RREADY_I)
         s_n.rvalid = 1'b0;
      if (rd_fire)
      begin
         s_n.rvalid = 1'b1;
         s_n.rdata  = rd_word;
         s_n.rresp  = (rd_dec[5:3] == KIND_NONE) ? RESP_SLVERR : RESP_OKAY;
      end

      // DAC code selection by profile and profile-zero mode
      for (int i = 0; i < NUM_CH; i++)
      begin
         if (prof != 2'b00)
            s_n.dac[i] = s_r.pcode[i][8*prof +: 8];
         else if (s_r.mode[i] == MODE_HOST || s_r.mode[i] == MODE_LOOP)
            s_n.dac[i] = s_r.trim[i];
         else
            s_n.dac[i] = s_r.pcode[i][7:0];
      end
   end

   always_ff @(posedge REF_CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         s_r       <= '0;
         s_r.st    <= FSM_IDLE;
         s_r.rate  <= RATE_RESET;
         s_r.trim  <= {NUM_CH{CODE_BPZ}};
         s_r.pcode <= {NUM_CH{PCODE_RESET}};
         s_r.dac   <= {NUM_CH{CODE_BPZ}};
      end
      else
         s_r <= s_n;
   end

   assign AWREADY_O    = wr_fire;
   assign WREADY_O     = wr_fire;
   assign BVALID_O     = s_r.bvalid;
   assign BRESP_O      = s_r.bresp;
   assign ARREADY_O    = rd_fire;
   assign RVALID_O     = s_r.rvalid;
   assign RDATA_O      = s_r.rdata;
   assign RRESP_O      = s_r.rresp;
   assign ADC_REQ_O    = s_r.adc_req;
   assign ADC_CH_O     = s_r.ch;
   assign DAC_CODE_O   = s_r.dac;
   assign OFFSET_SEL_O = s_r.ofs;
   assign TRIM_LOCK_O  = s_r.lock;

   default clocking cb @(posedge REF_CLK_I);
   endclocking
   default disable iff (!RESET_N_I);

   chk_start_on_tick: assert property (
      (s_r.st == FSM_IDLE && tick && run_ok && any_loop && !rst_cmd) |=> s_r.st == FSM_SEL)
      else $error("correction cycle did not start on the interval tick");

   chk_no_start_paused: assert property (
      (s_r.st == FSM_IDLE && !run_ok) |=> s_r.st == FSM_IDLE)
      else $error("correction cycle started while paused");

   chk_adc_own_index: assert property (
      ADC_REQ_O |-> s_r.mode[ADC_CH_O] == MODE_LOOP && s_r.st == FSM_WAIT)
      else $error("measurement requested for a channel not in closed loop");

   chk_finish_cycle: assert property (
      (s_r.st != FSM_IDLE && !rst_cmd) |=> (s_r.st != FSM_IDLE || $past(s_r.st) == FSM_NEXT))
      else $error("correction cycle abandoned before its end");

   chk_hold_paused: assert property (
      (s_r.st == FSM_IDLE && !wr_trim && !rst_cmd) |=> $stable(s_r.trim))
      else $error("trim code moved while trimming was paused");

   chk_reset_code: assert property (
      (rst_cmd && s_r.mode[0] == MODE_LOOP) |=> s_r.trim[0] == CODE_BPZ && !TRIM_LOCK_O)
      else $error("reset command did not recentre the code and drop lock");

   chk_no_wrap: assert property (
      (s_r.trim[0] == CODE_MAX && !wr_trim && !rst_cmd) |=> s_r.trim[0] != CODE_MIN)
      else $error("trim code wrapped past full scale");

   chk_profile_code: assert property (
      (prof != 2'b00) |=> DAC_CODE_O[CODE_W-1:0] == $past(prof_code0))
      else $error("profile code not routed to the DAC");

   chk_stored_mode: assert property (
      (prof == 2'b00 && s_r.mode[0] == MODE_STORED) |=> DAC_CODE_O[CODE_W-1:0]
         == $past(s_r.pcode[0][7:0]))
      else $error("stored-code channel not driven from its stored code");

endmodule
